// ==== logic/sdp_debug_port.sv ====
/*
  Debug command interpreter behind one open-drain serial pin.
  Assumes the processor side runs on clk_i, the program memory answers one
  cycle after prog_rd_o, and exec_len_i decodes wdata_o combinationally.
*/
// Overview of operation
// - One shared open-drain line, pulled up externally.
// - Half-duplex, never transmit and receive together.
// - Bytes framed as standard asynchronous serial characters.
// - Counter read returns inverted counter, else ones.
// - Counter matching program counter raises break.
// - Control write loads following byte into control.
// - Under read protect debug bit only sets.
// - Control read replies current control register.
// - Program counter write dropped unless debug, unprotected.
// - Program counter read, ones unless debug, unprotected.
// - Register write: address, size, data; zero means 256.
// - Register writes dropped outside debug; protect limits flash.
// - Memory read: address, size, bytes; ones outside debug.
// - CRC-CCITT over program memory, ones outside debug.
// - CRC reply delayed one cycle per byte.
// - Step executes one instruction when allowed.
// - Stuff sends host opcode, rest from memory.
// - Execute passes whole host instruction when allowed.
`timescale 1ns/1ps
module sdp_debug_port
  import sdp_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES,
  parameter int PROG_BYTES_P = PROG_BYTES
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        debug_line_i,
  output logic             debug_line_o,
  output logic             debug_line_oe_n_o,
  input  wire logic        read_protect_i,
  input  wire logic [15:0] pc_i,
  input  wire logic        instr_done_i,
  output logic             pc_load_o,
  output logic [15:0]      pc_wdata_o,
  output logic             reg_wr_o,
  output logic [11:0]      reg_addr_o,
  output logic [7:0]       wdata_o,
  output logic             mem_rd_o,
  output logic [15:0]      mem_addr_o,
  input  wire logic [7:0]  mem_rdata_i,
  input  wire logic        mem_rvalid_i,
  output logic             prog_rd_o,
  output logic [15:0]      prog_addr_o,
  input  wire logic [7:0]  prog_rdata_i,
  output logic             step_o,
  output logic             stuff_o,
  output logic             exec_valid_o,
  output logic             exec_first_o,
  input  wire logic [2:0]  exec_len_i,
  output logic             break_request_o,
  output logic             debug_mode_bit_o,
  output logic [7:0]       debug_control_reg_o
);

  typedef enum logic [3:0] {
    S_CMD, S_ARG, S_WREG, S_MRD, S_MWAIT, S_SEND, S_CRC, S_ELEN, S_EXEC
  } sdp_st_e;

  typedef struct packed {
    sdp_st_e     st;
    logic [7:0]  cmd;
    logic [2:0]  argn;
    logic [31:0] args;
    logic [7:0]  ctl;
    logic [15:0] cnt_inv;
    logic [16:0] len;
    logic [15:0] addr;
    logic [15:0] reply;
    logic [1:0]  rep_n;
    logic [15:0] crc;
    logic [16:0] crc_i;
    logic [1:0]  crc_v;
    logic [2:0]  exn;
    logic        pc_load;
    logic [15:0] pc_wdata;
    logic        reg_wr;
    logic [11:0] reg_addr;
    logic [7:0]  wdata;
    logic        mem_rd;
    logic [15:0] mem_addr;
    logic        prog_rd;
    logic [15:0] prog_addr;
    logic        step;
    logic        stuff;
    logic        exec_v;
    logic        exec_first;
    logic        break_request;
  } sdp_core_s;

  localparam logic [16:0] PROG_N = 17'(PROG_BYTES_P);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  function automatic logic is_flash(input logic [11:0] a);
    return (a >= FLASH_LO) && (a <= FLASH_HI);
  endfunction

  sdp_ser_if ser ();

  sdp_uart #(
    .BIT_CYCLES_P (BIT_CYCLES_P)
  ) u_uart (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .line_i       (debug_line_i),
    .line_oe_n_o  (debug_line_oe_n_o),
    .ser          (ser.uart)
  );

  sdp_core_s   q;
  sdp_core_s   next_q;
  logic        dbg;
  logic        ok;
  logic [31:0] na;

  assign dbg = q.ctl[CTL_DBG_BIT];
  assign ok  = dbg && !read_protect_i;
  assign na  = {q.args[23:0], ser.rx_data};

  // Reply bytes leave high byte first
  assign ser.tx_valid = (q.st == S_SEND) && (q.rep_n != 2'd0);
  assign ser.tx_data  = (q.rep_n == 2'd2) ? q.reply[15:8] : q.reply[7:0];

  always_comb begin
    next_q            = q;
    next_q.pc_load    = 1'b0;
    next_q.reg_wr     = 1'b0;
    next_q.mem_rd     = 1'b0;
    next_q.prog_rd    = 1'b0;
    next_q.step       = 1'b0;
    next_q.stuff      = 1'b0;
    next_q.exec_v     = 1'b0;
    next_q.exec_first = 1'b0;
    // Counter held inverted so that reset to zero gives the all-ones count
    if (instr_done_i && (q.cnt_inv != ALL_ONES)) begin
      next_q.cnt_inv = q.cnt_inv + 16'h0001;
    end
    next_q.break_request = q.ctl[CTL_BRK_BIT] && (~q.cnt_inv == pc_i);
    case (q.st)
      S_CMD: begin
        if (ser.rx_valid) begin
          next_q.cmd  = ser.rx_data;
          next_q.args = 32'h0000_0000;
          case (ser.rx_data)
            CMD_RD_CNT: begin
              next_q.reply = dbg ? q.cnt_inv : ALL_ONES;
              next_q.rep_n = 2'd2;
              next_q.st    = S_SEND;
            end
            CMD_WR_CTL: begin
              next_q.argn = 3'd1;
              next_q.st   = S_ARG;
            end
            CMD_RD_CTL: begin
              next_q.reply = {8'h00, q.ctl};
              next_q.rep_n = 2'd1;
              next_q.st    = S_SEND;
            end
            CMD_WR_PC: begin
              next_q.argn = 3'd2;
              next_q.st   = S_ARG;
            end
            CMD_RD_PC: begin
              next_q.reply = ok ? pc_i : ALL_ONES;
              next_q.rep_n = 2'd2;
              next_q.st    = S_SEND;
            end
            CMD_WR_REG: begin
              next_q.argn = 3'd3;
              next_q.st   = S_ARG;
            end
            CMD_RD_MEM: begin
              next_q.argn = 3'd4;
              next_q.st   = S_ARG;
            end
            CMD_CRC: begin
              if (dbg) begin
                next_q.crc   = CRC_INIT;
                next_q.crc_i = 17'h00000;
                next_q.crc_v = 2'h0;
                next_q.st    = S_CRC;
              end else begin
                next_q.reply = ALL_ONES;
                next_q.rep_n = 2'd2;
                next_q.st    = S_SEND;
              end
            end
            CMD_STEP: begin
              next_q.step = ok;
            end
            CMD_STUFF: begin
              next_q.argn = 3'd1;
              next_q.st   = S_ARG;
            end
            CMD_EXEC: begin
              next_q.st = S_EXEC;
            end
            default: begin
              next_q.st = S_CMD;
            end
          endcase
        end
      end
      S_ARG: begin
        if (ser.rx_valid) begin
          next_q.args = na;
          next_q.argn = q.argn - 3'd1;
          if (q.argn == 3'd1) begin
            next_q.st = S_CMD;
            case (q.cmd)
              CMD_WR_CTL: begin
                next_q.ctl = ser.rx_data;
                if (read_protect_i) begin
                  next_q.ctl[CTL_DBG_BIT] = ser.rx_data[CTL_DBG_BIT] | dbg;
                end
              end
              CMD_WR_PC: begin
                next_q.pc_load  = ok;
                next_q.pc_wdata = na[15:0];
              end
              CMD_WR_REG: begin
                next_q.addr = {4'h0, na[19:8]};
                next_q.len  = (na[7:0] == 8'h00) ? REG_SIZE0 : {9'h000, na[7:0]};
                next_q.st   = S_WREG;
              end
              CMD_RD_MEM: begin
                next_q.addr = na[31:16];
                next_q.len  = (na[15:0] == 16'h0000) ? MEM_SIZE0 : {1'b0, na[15:0]};
                next_q.st   = S_MRD;
              end
              CMD_STUFF: begin
                next_q.stuff = ok;
                next_q.wdata = ser.rx_data;
              end
              default: begin
                next_q.st = S_CMD;
              end
            endcase
          end
        end
      end
      S_WREG: begin
        if (ser.rx_valid) begin
          // Dropped bytes are still counted so the stream stays aligned
          next_q.reg_wr   = dbg && (!read_protect_i || is_flash(q.addr[11:0]));
          next_q.reg_addr = q.addr[11:0];
          next_q.wdata    = ser.rx_data;
          next_q.addr     = q.addr + 16'h0001;
          next_q.len      = q.len - 17'h00001;
          if (q.len == 17'h00001) begin
            next_q.st = S_CMD;
          end
        end
      end
      S_MRD: begin
        next_q.addr = q.addr + 16'h0001;
        next_q.len  = q.len - 17'h00001;
        if (dbg) begin
          next_q.mem_rd   = 1'b1;
          next_q.mem_addr = q.addr;
          next_q.st       = S_MWAIT;
        end else begin
          next_q.reply = {8'h00, BYTE_ONES};
          next_q.rep_n = 2'd1;
          next_q.st    = S_SEND;
        end
      end
      S_MWAIT: begin
        if (mem_rvalid_i) begin
          next_q.reply = {8'h00, mem_rdata_i};
          next_q.rep_n = 2'd1;
          next_q.st    = S_SEND;
        end
      end
      S_SEND: begin
        if (q.rep_n != 2'd0) begin
          if (ser.tx_ready) begin
            next_q.rep_n = q.rep_n - 2'd1;
          end
        end else if ((q.cmd == CMD_RD_MEM) && (q.len != 17'h00000)) begin
          next_q.st = S_MRD;
        end else begin
          next_q.st = S_CMD;
        end
      end
      S_CRC: begin
        // One byte per cycle, so the reply lags by about the memory size
        if (q.crc_v[1]) begin
          next_q.crc = crc_byte(q.crc, prog_rdata_i);
        end
        // Memory answers a cycle after the address, so validity trails by two
        next_q.crc_v = {q.crc_v[0], 1'b0};
        if (q.crc_i < PROG_N) begin
          next_q.prog_rd   = 1'b1;
          next_q.prog_addr = q.crc_i[15:0];
          next_q.crc_i     = q.crc_i + 17'h00001;
          next_q.crc_v[0]  = 1'b1;
        end else if (q.crc_v == 2'h0) begin
          next_q.reply = q.crc;
          next_q.rep_n = 2'd2;
          next_q.st    = S_SEND;
        end
      end
      S_ELEN: begin
        if (exec_len_i <= 3'd1) begin
          next_q.st = S_CMD;
        end else begin
          next_q.exn = exec_len_i - 3'd1;
          next_q.st  = S_EXEC;
        end
      end
      S_EXEC: begin
        if (ser.rx_valid) begin
          next_q.exec_v     = ok;
          next_q.exec_first = (q.exn == 3'd0);
          next_q.wdata      = ser.rx_data;
          if (q.exn == 3'd0) begin
            next_q.st = S_ELEN;
          end else begin
            next_q.exn = q.exn - 3'd1;
            if (q.exn == 3'd1) begin
              next_q.st = S_CMD;
            end
          end
        end
      end
      default: begin
        next_q.st = S_CMD;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else if (clk_en_i) begin
      q <= next_q;
    end
  end

  assign debug_line_o        = 1'b0;
  assign pc_load_o           = q.pc_load;
  assign pc_wdata_o          = q.pc_wdata;
  assign reg_wr_o            = q.reg_wr;
  assign reg_addr_o          = q.reg_addr;
  assign wdata_o             = q.wdata;
  assign mem_rd_o            = q.mem_rd;
  assign mem_addr_o          = q.mem_addr;
  assign prog_rd_o           = q.prog_rd;
  assign prog_addr_o         = q.prog_addr;
  assign step_o              = q.step;
  assign stuff_o             = q.stuff;
  assign exec_valid_o        = q.exec_v;
  assign exec_first_o        = q.exec_first;
  assign break_request_o     = q.break_request;
  assign debug_mode_bit_o    = dbg;
  assign debug_control_reg_o = q.ctl;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_CNT_ONES: assert property (clk_en_i && q.st == S_CMD && ser.rx_valid &&
      ser.rx_data == CMD_RD_CNT && !dbg |=> q.reply == ALL_ONES && q.rep_n == 2'd2)
    else $error("counter read outside debug not all ones");
  AST_CNT_INV: assert property (clk_en_i && q.st == S_CMD && ser.rx_valid &&
      ser.rx_data == CMD_RD_CNT && dbg |=> ~q.reply == $past(~q.cnt_inv))
    else $error("counter read not inverted");
  AST_DBG_STICKY: assert property (read_protect_i && dbg |=> dbg)
    else $error("debug bit cleared under read protect");
  AST_CTL_READ: assert property (clk_en_i && q.st == S_CMD && ser.rx_valid &&
      ser.rx_data == CMD_RD_CTL |=> q.reply[7:0] == $past(q.ctl) && q.st == S_SEND)
    else $error("control read reply wrong");
  AST_PC_GUARD: assert property (pc_load_o |-> $past(ok))
    else $error("program counter loaded while not allowed");
  AST_PC_ONES: assert property (clk_en_i && q.st == S_CMD && ser.rx_valid &&
      ser.rx_data == CMD_RD_PC && !ok |=> q.reply == ALL_ONES)
    else $error("program counter read not all ones");
  AST_REG_GUARD: assert property (reg_wr_o |-> dbg &&
      (!$past(read_protect_i) || is_flash(reg_addr_o)))
    else $error("register write not allowed");
  AST_STEP_PULSE: assert property (step_o && clk_en_i |=> !step_o)
    else $error("step lasted more than one cycle");
  AST_BRK_MATCH: assert property (clk_en_i && q.ctl[CTL_BRK_BIT] &&
      ~q.cnt_inv == pc_i |=> break_request_o)
    else $error("break not raised on counter match");
  AST_UNKNOWN: assert property (clk_en_i && q.st == S_CMD && ser.rx_valid &&
      ser.rx_data == 8'h00 |=> q.st == S_CMD ##1 debug_line_oe_n_o)
    else $error("unknown command not ignored");

  COV_CRC_DONE: cover property (q.st == S_CRC ##1 q.st == S_SEND);
  COV_MEM_READ: cover property (mem_rd_o ##[1:8] mem_rvalid_i);
  COV_REG_WRITE: cover property (reg_wr_o);
  COV_EXEC: cover property (exec_valid_o && exec_first_o);

endmodule // sdp_debug_port

// ==== logic/sdp_pkg.sv ====
/*
  Shared constants for the single-pin debug command port: command codes,
  control register layout, timing and CRC figures.
  Assumes a 20 MHz system clock; the bit rate is fixed by both parties.
*/
package sdp_pkg;

  localparam int CLK_HZ      = 20_000_000;
  localparam int BAUD_RATE   = 57_600;
  // Cycles per serial bit, derived from the clock and the agreed bit rate
  localparam int BIT_CYCLES  = CLK_HZ / BAUD_RATE;
  localparam int PROG_BYTES  = 4096;

  localparam logic [7:0] CMD_RD_CNT = 8'h03;
  localparam logic [7:0] CMD_WR_CTL = 8'h04;
  localparam logic [7:0] CMD_RD_CTL = 8'h05;
  localparam logic [7:0] CMD_WR_PC  = 8'h06;
  localparam logic [7:0] CMD_RD_PC  = 8'h07;
  localparam logic [7:0] CMD_WR_REG = 8'h08;
  localparam logic [7:0] CMD_RD_MEM = 8'h0D;
  localparam logic [7:0] CMD_CRC    = 8'h0E;
  localparam logic [7:0] CMD_STEP   = 8'h10;
  localparam logic [7:0] CMD_STUFF  = 8'h11;
  localparam logic [7:0] CMD_EXEC   = 8'h12;

  localparam int          CTL_DBG_BIT = 7;
  localparam int          CTL_BRK_BIT = 6;
  localparam logic [7:0]  CTL_RESET   = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'hFFFF;
  localparam logic [15:0] ALL_ONES    = 16'hFFFF;
  localparam logic [7:0]  BYTE_ONES   = 8'hFF;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [11:0] FLASH_LO    = 12'hFF8;
  localparam logic [11:0] FLASH_HI    = 12'hFFB;
  localparam logic [16:0] REG_SIZE0   = 17'h00100;
  localparam logic [16:0] MEM_SIZE0   = 17'h10000;

endpackage

// ==== logic/sdp_ser_if.sv ====
/*
  Byte stream carrier between the command core and the serial engine.
  Assumes both ends share one clock; tx_ready is high only while idle.
*/
`timescale 1ns/1ps
interface sdp_ser_if;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_data;
  modport uart (output rx_valid, rx_data, tx_ready, input tx_valid, tx_data);
  modport core (input rx_valid, rx_data, tx_ready, output tx_valid, tx_data);
endinterface

// ==== logic/sdp_uart.sv ====
/*
  Half-duplex serial engine for the open-drain debug line.
  Assumes an external pull-up; the line input comes from the pin, unsynchronised.
*/
`timescale 1ns/1ps
module sdp_uart
  import sdp_pkg::*;
#(
  parameter int BIT_CYCLES_P = BIT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  input  wire logic line_i,
  output logic      line_oe_n_o,
  sdp_ser_if.uart   ser
);

  typedef enum logic [2:0] {U_IDLE, U_RXS, U_RXD, U_RXP, U_TX} sdp_umode_e;

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    sdp_umode_e mode;
    logic [15:0] cnt;
    logic [3:0]  bitn;
    logic [9:0]  sh;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        oe_n;
  } sdp_uart_s;

  localparam logic [15:0] BITC = 16'(BIT_CYCLES_P - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES_P / 2);

  sdp_uart_s q;
  sdp_uart_s next_q;

  always_comb begin
    next_q          = q;
    next_q.sync1    = line_i;
    next_q.sync2    = q.sync1;
    next_q.rx_valid = 1'b0;
    case (q.mode)
      U_IDLE: begin
        // Transmit wins; the receiver is off while sending so our own bits never echo
        if (ser.tx_valid) begin
          next_q.sh   = {1'b1, ser.tx_data, 1'b0};
          next_q.bitn = 4'h0;
          next_q.cnt  = 16'h0000;
          next_q.mode = U_TX;
        end else if (!q.sync2) begin
          next_q.cnt  = 16'h0000;
          next_q.mode = U_RXS;
        end
      end
      U_RXS: begin
        if (q.cnt == HALF) begin
          next_q.cnt  = 16'h0000;
          next_q.bitn = 4'h0;
          next_q.mode = q.sync2 ? U_IDLE : U_RXD;
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      U_RXD: begin
        if (q.cnt == BITC) begin
          next_q.cnt  = 16'h0000;
          next_q.sh   = {q.sync2, q.sh[9:1]};
          next_q.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'h7) begin
            next_q.mode = U_RXP;
          end
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      U_RXP: begin
        if (q.cnt == BITC) begin
          // A bad stop bit drops the character
          next_q.rx_valid = q.sync2;
          next_q.rx_data  = q.sh[9:2];
          next_q.mode     = U_IDLE;
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      U_TX: begin
        if (q.cnt == BITC) begin
          next_q.cnt  = 16'h0000;
          next_q.sh   = {1'b1, q.sh[9:1]};
          next_q.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'h9) begin
            next_q.mode = U_IDLE;
          end
        end else begin
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      default: next_q.mode = U_IDLE;
    endcase
    // Open drain: only ever pull low, never drive high
    next_q.oe_n = !((next_q.mode == U_TX) && !next_q.sh[0]);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '{sync1: 1'b1, sync2: 1'b1, mode: U_IDLE, oe_n: 1'b1, default: '0};
    end else if (clk_en_i) begin
      q <= next_q;
    end
  end

  assign line_oe_n_o  = q.oe_n;
  assign ser.rx_valid = q.rx_valid;
  assign ser.rx_data  = q.rx_data;
  assign ser.tx_ready = (q.mode == U_IDLE);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_NO_DRIVE_RX: assert property ((q.mode != U_TX) |-> line_oe_n_o)
    else $error("debug line driven while receiving");
  AST_START_BIT: assert property (clk_en_i && ser.tx_valid && ser.tx_ready |=> !line_oe_n_o)
    else $error("start bit not driven after byte accepted");

endmodule // sdp_uart

// ==== sim/sdp_host.sv ====
/*
  Debug host model: sends and receives serial characters on the debug line.
  Assumes the bench resolves the open-drain line with a pull-up.
*/
`timescale 1ns/1ps
module sdp_host #(
  parameter int BC = 8
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      pull_o
);
  initial pull_o = 1'b0;
  // Only ever pulls low, release leaves the pull-up in charge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      pull_o <= ~f[i];
      repeat (BC) @(posedge clk_i);
    end
  endtask
  // Waits out the device's stop bit so the host never talks over it
  task automatic recv(output logic [7:0] b);
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (BC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (BC + BC / 2) @(posedge clk_i);
  endtask
endmodule // sdp_host

// ==== sim/testbench.sv ====
/*
  Self-checking bench for the debug port, host model on the line.
  Assumes short bit time and program size parameters.
*/
`timescale 1ns/1ps
module testbench;
  import sdp_pkg::*;
  localparam int BC = 8;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, rp = 1'b0, mrv = 1'b0, pull, idn = 1'b0;
  logic        oe_n, pc_ld, rwr, mrd, prd, stp, stf, ev, ef, break_request, dbg;
  logic [2:0]  elen = 3'h2;
  logic [15:0] pc = 16'h0000, pcw, ma, pa, v;
  logic [11:0] ra, la;
  logic [7:0]  wd, ctl, ld, b, mrdata = 8'h00, prdata = 8'h00;
  int          error_cnt = 0, comparisons = 0, n_ld = 0, n_wr = 0, n_rd = 0, n_st = 0;
  int          n_sf = 0, n_ex = 0, n_ef = 0, n_pr = 0;
  wire         line = ~(pull | ~oe_n);
  always #25 clk_i = ~clk_i;
  // Memories answer with the low address byte, one cycle late
  always @(posedge clk_i) begin
    mrv <= mrd;
    mrdata <= ma[7:0];
    prdata <= pa[7:0];
    n_ld += (pc_ld === 1'b1);
    n_st += (stp === 1'b1);
    n_rd += (mrd === 1'b1);
    n_sf += (stf === 1'b1);
    n_ex += (ev === 1'b1);
    n_ef += (ef === 1'b1);
    n_pr += (prd === 1'b1);
    if (rwr === 1'b1) begin
      n_wr++;
      la <= ra;
      ld <= wd;
    end
  end
  sdp_debug_port #(.BIT_CYCLES_P(BC), .PROG_BYTES_P(16)) dut (
    .clk_i, .sys_rst_i, .clk_en_i(1'b1), .debug_line_i(line),
    .debug_line_o(), .debug_line_oe_n_o(oe_n), .read_protect_i(rp), .pc_i(pc),
    .instr_done_i(idn), .pc_load_o(pc_ld), .pc_wdata_o(pcw), .reg_wr_o(rwr),
    .reg_addr_o(ra), .wdata_o(wd), .mem_rd_o(mrd), .mem_addr_o(ma),
    .mem_rdata_i(mrdata), .mem_rvalid_i(mrv), .prog_rd_o(prd), .prog_addr_o(pa),
    .prog_rdata_i(prdata), .step_o(stp), .stuff_o(stf), .exec_valid_o(ev),
    .exec_first_o(ef), .exec_len_i(elen), .break_request_o(break_request),
    .debug_mode_bit_o(dbg), .debug_control_reg_o(ctl));
  sdp_host #(.BC(BC)) host (.clk_i, .line_i(line), .pull_o(pull));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic snd(input logic [47:0] s, input int n);
    for (int i = 0; i < n; i++) host.send(s[8*(n-1-i) +: 8]);
  endtask
  task automatic rd16(input logic [7:0] c, output logic [15:0] r);
    host.send(c);
    host.recv(r[15:8]);
    host.recv(r[7:0]);
  endtask
  task automatic idle;
    repeat (4 * BC) @(posedge clk_i);
  endtask
  // Reference CRC over the model's program bytes 0..15
  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    c = CRC_INIT;
    for (int a = 0; a < 16; a++) begin
      for (int i = 7; i >= 0; i--) begin
        c = {c[14:0], 1'b0} ^ (((c[15] ^ a[i]) == 1'b1) ? CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  task automatic t_unk;
    int k;
    k = 0;
    snd(48'h00FF, 2);
    repeat (20 * BC) @(posedge clk_i) k += (oe_n === 1'b0);
    chk(16'(k), 16'h0000);
  endtask
  task automatic t_locked;
    rd16(CMD_RD_CNT, v); chk(v, ALL_ONES);
    rd16(CMD_RD_PC, v); chk(v, ALL_ONES);
    rd16(CMD_CRC, v); chk(v, ALL_ONES);
    snd(48'h0D00050001, 5);
    host.recv(b); chk({8'h00, b}, 16'h00FF);
    snd(48'h06ABCD, 3); snd(48'h10, 1); snd(48'h0800120155, 5);
    idle;
    chk(16'(n_ld + n_st + n_wr + n_rd), 16'h0000);
  endtask
  task automatic t_ctl;
    snd(48'h0480, 2);
    host.send(CMD_RD_CTL); host.recv(b); chk({8'h00, b}, 16'h0080);
    chk({15'h0, dbg}, 16'h0001);
  endtask
  task automatic t_debug;
    idn <= 1'b1;
    repeat (3) @(posedge clk_i);
    idn <= 1'b0;
    rd16(CMD_RD_CNT, v); chk(v, ~(CNT_RESET - 16'h0003));
    rd16(CMD_RD_PC, v); chk(v, 16'h1234);
    snd(48'h06ABCD, 3); idle;
    chk(16'(n_ld), 16'h0001); chk(pcw, 16'hABCD);
    snd(48'h10, 1); idle; chk(16'(n_st), 16'h0001);
    snd(48'h0D00300002, 5);
    host.recv(b); chk({8'h00, b}, 16'h0030);
    host.recv(b); chk({8'h00, b}, 16'h0031);
    chk(16'(n_rd), 16'h0002);
    snd(48'h080012025AA5, 6); idle;
    chk(16'(n_wr), 16'h0002); chk({4'h0, la}, 16'h0013); chk({8'h00, ld}, 16'h00A5);
  endtask
  task automatic t_ops;
    rd16(CMD_CRC, v); chk(v, crc_exp());
    chk(16'(n_pr), 16'h0010);
    snd(48'h1140, 2);
    idle;
    chk(16'(n_sf), 16'h0001); chk({8'h00, wd}, 16'h0040);
    snd(48'h12AABB, 3);
    idle;
    chk(16'(n_ex), 16'h0002); chk(16'(n_ef), 16'h0001);
    chk({8'h00, wd}, 16'h00BB);
    snd(48'h04C0, 2);
    idle;
    chk({8'h00, ctl}, 16'h00C0);
    pc <= CNT_RESET - 16'h0003;
    idle;
    chk({15'h0, break_request}, 16'h0001);
    pc <= 16'h1234;
  endtask
  task automatic t_prot;
    @(posedge clk_i);
    rp <= 1'b1;
    snd(48'h0400, 2);
    host.send(CMD_RD_CTL); host.recv(b); chk({15'h0, b[7]}, 16'h0001);
    rd16(CMD_RD_PC, v); chk(v, ALL_ONES);
    snd(48'h061111, 3); snd(48'h10, 1); idle;
    chk(16'(n_ld + n_st), 16'h0002);
    snd(48'h080FF80177, 5); snd(48'h0800120166, 5); idle;
    chk(16'(n_wr), 16'h0003); chk({4'h0, la}, 16'h0FF8);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({8'h00, ctl}, {8'h00, CTL_RESET});
  endtask
  task tally_and_finish;
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    pc <= 16'h1234;
    t_unk; t_locked; t_ctl; t_debug; t_ops; t_prot;
    tally_and_finish;
  end
  // About 84 characters of 80 cycles plus waits fit well inside this span
  initial begin
    repeat (40000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish;
  end
endmodule // testbench
